// ### core/sris_top.sv
// Reset sequencer, reset cause register, watchdog and interrupt latch of the system integration unit.
// Assumes clk_in is the 4x oscillator clock, CPU signals share it, and pins arrive asynchronously.
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "sris_params.svh"

// Contract
// - Power-on: internal reset, count 4096 cycles, release 64 cycles later.
// - Power-on keeps CPU and module clocks off for 4096 cycles.
// - Power-on sets the power-on cause bit.
// - Watchdog overflow gives internal reset and sets the watchdog cause bit.
// - Every internal reset source drives the reset pin low.
// - Any write to the top address clears watchdog and counter stages 12 to 5.
// - Stabilisation counter ticks the watchdog every 4096 cycles while free-running.
// - Watchdog stops in monitor-mode break when break watchdog disable is set.
// - Illegal instruction sets illegal opcode cause bit and resets.
// - Stop with stop-enable clear is an illegal opcode reset.
// - Opcode fetch from unmapped address resets; data fetch does not.
// - Low voltage sets cause, holds pin low, counts 4096, releases 64 later.
// - Counter has twelve stages and a thirteenth that wraps and clocks watchdog.
// - Counter advances on the falling clock edge.
// - Stop instruction clears the counter.
// - Stop exit waits 32 cycles if short recovery set, else 4096.
// - Pin reset leaves counter alone; counter free-runs after every reset.
// - A latched interrupt keeps precedence until serviced or mask cleared.
// - Interrupts taken at instruction end, only unmasked and enabled.
// - Highest priority pending interrupt is serviced first.
// - Interrupt pending at return is serviced before the next instruction.
// - Internal resets drive pin low 32 cycles, then hold reset 32 more.
// - Internal resets clear the counter; pin reset does not.
module sris_top
    import sris_pkg::*;
#(
    parameter int IRQ_COUNT = 8,
    parameter int IDX_WIDTH = 3,
    parameter int WDOG_WIDTH = 6
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic [15:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [7:0] rdata_out,
    input wire sris_cpu_type cpu_in,
    input wire logic [IRQ_COUNT-1:0] irq_req_in,
    input wire logic [IRQ_COUNT-1:0] irq_enable_in,
    input wire logic ext_reset_n_in,
    input wire logic low_voltage_in,
    output logic reset_pin_out,
    output logic reset_pin_oe_out,
    output logic internal_reset_out,
    output logic bus_clk_enable_out,
    output logic irq_valid_out,
    output logic [IDX_WIDTH-1:0] irq_index_out
);

    sris_state_type state_q, state_d;
    logic [5:0] cnt_q;
    logic [5:0] cause_q;
    logic [3:0] config_q;
    logic ext_meta_q, ext_sync_q;
    logic lv_meta_q, lv_sync_q;
    logic [WDOG_WIDTH-1:0] wdog_q;
    logic stab_clear_q, stab_service_q, short_stop_recovery_q;
    logic pin_oe_q, int_reset_q, bus_en_q;
    logic [7:0] rdata_q;
    logic [`SRIS_STAB_STAGES-1:0] stab_count;
    logic stab_tick, tick_q;
    logic service_wr, wdog_run, wdog_over;
    logic ev_illegal_opcode_flag, ev_illegal_address_flag, ev_wdog;
    logic enter_clear;
    logic [5:0] cause_set;

    // Two flops on each pin before any logic reads it
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            ext_meta_q <= 1'b1;
            ext_sync_q <= 1'b1;
            lv_meta_q <= 1'b0;
            lv_sync_q <= 1'b0;
        end else if (ce_in) begin
            ext_meta_q <= ext_reset_n_in;
            ext_sync_q <= ext_meta_q;
            lv_meta_q <= low_voltage_in;
            lv_sync_q <= lv_meta_q;
        end
    end

    sris_stab_counter u_stab (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .clear_in(stab_clear_q),
        .service_in(stab_service_q),
        .count_out(stab_count),
        .tick_out(stab_tick)
    );

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            tick_q <= 1'b0;
        end else if (ce_in) begin
            tick_q <= stab_tick;
        end
    end

    assign service_wr = wr_in && (addr_in == `SRIS_ADDR_WDOG_SERVICE);
    assign wdog_run = config_q[`SRIS_CFG_WDOG_ENABLE] && !(cpu_in.break_active && cpu_in.monitor_mode
                      && config_q[`SRIS_CFG_BREAK_WDOG_DIS]);
    assign wdog_over = wdog_run && tick_q && (&wdog_q);

    // Reset events, only while the CPU runs
    assign ev_wdog = (state_q == SRIS_ST_RUN) && wdog_over;
    assign ev_illegal_opcode_flag = (state_q == SRIS_ST_RUN) && (cpu_in.illegal_opcode ||
                     (cpu_in.stop_exec && !config_q[`SRIS_CFG_STOP_ENABLE]));
    assign ev_illegal_address_flag = (state_q == SRIS_ST_RUN) && cpu_in.opcode_fetch && cpu_in.addr_unmapped;

    // Watchdog counter, clocked by the thirteenth stage
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wdog_q <= '0;
        end else if (ce_in) begin
            if (service_wr || int_reset_q) begin
                wdog_q <= '0;
            end else if (wdog_run && tick_q) begin
                wdog_q <= wdog_q + 1'b1;
            end
        end
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            SRIS_ST_RUN: begin
                if (lv_sync_q) begin
                    state_d = SRIS_ST_LV;
                end else if (ev_wdog || ev_illegal_opcode_flag || ev_illegal_address_flag) begin
                    state_d = SRIS_ST_PIN;
                end else if (!ext_sync_q) begin
                    state_d = SRIS_ST_EXT;
                end else if (cpu_in.stop_exec) begin
                    state_d = SRIS_ST_STOP;
                end
            end
            SRIS_ST_STAB: begin
                if (lv_sync_q) begin
                    state_d = SRIS_ST_LV;
                end else if (tick_q) begin
                    state_d = SRIS_ST_PIN;
                end
            end
            SRIS_ST_PIN: begin
                if (lv_sync_q) begin
                    state_d = SRIS_ST_LV;
                end else if (cnt_q == `SRIS_PIN_LOW_CYCLES - 6'h01) begin
                    state_d = SRIS_ST_HOLD;
                end
            end
            SRIS_ST_HOLD: begin
                if (lv_sync_q) begin
                    state_d = SRIS_ST_LV;
                end else if (cnt_q == `SRIS_HOLD_CYCLES - 6'h01) begin
                    state_d = SRIS_ST_RUN;
                end
            end
            SRIS_ST_LV: begin
                if (!lv_sync_q) begin
                    state_d = SRIS_ST_STAB;
                end
            end
            SRIS_ST_STOP: begin
                if (lv_sync_q) begin
                    state_d = SRIS_ST_LV;
                end else if (!ext_sync_q) begin
                    state_d = SRIS_ST_EXT;
                end else if (cpu_in.wake) begin
                    state_d = SRIS_ST_STOPREC;
                end
            end
            SRIS_ST_STOPREC: begin
                if (lv_sync_q) begin
                    state_d = SRIS_ST_LV;
                end else if (short_stop_recovery_q ? stab_count[`SRIS_SHORT_REC_STAGE] : tick_q) begin
                    state_d = SRIS_ST_RUN;
                end
            end
            SRIS_ST_EXT: begin
                if (lv_sync_q) begin
                    state_d = SRIS_ST_LV;
                end else if (ext_sync_q) begin
                    state_d = SRIS_ST_HOLD;
                end
            end
            default: begin
                state_d = SRIS_ST_STAB;
            end
        endcase
    end

    // Counter clears on entering an internal reset, stop or stop recovery, never on pin reset;
    // the clock runs on in stop, so recovery restarts the count at wake to get its full delay
    assign enter_clear = (state_d != state_q) && ((state_d == SRIS_ST_PIN && state_q == SRIS_ST_RUN) ||
                         state_d == SRIS_ST_STAB || state_d == SRIS_ST_LV || state_d == SRIS_ST_STOP ||
                         state_d == SRIS_ST_STOPREC);

    // Power-on starts in the counting state with the counter already cleared
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= SRIS_ST_STAB;
            cnt_q <= '0;
        end else if (ce_in) begin
            state_q <= state_d;
            if (state_d != state_q) begin
                cnt_q <= '0;
            end else begin
                cnt_q <= cnt_q + 6'h01;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            stab_clear_q <= 1'b0;
            stab_service_q <= 1'b0;
        end else if (ce_in) begin
            stab_clear_q <= enter_clear;
            stab_service_q <= service_wr;
        end
    end

    // Short recovery choice is sampled at stop exit
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            short_stop_recovery_q <= 1'b0;
        end else if (ce_in && state_q == SRIS_ST_STOP && state_d == SRIS_ST_STOPREC) begin
            short_stop_recovery_q <= config_q[`SRIS_CFG_SHORT_STOP_REC];
        end
    end

    // Outputs follow the next state so they change with the state register
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            pin_oe_q <= 1'b1;
            int_reset_q <= 1'b1;
            bus_en_q <= 1'b0;
        end else if (ce_in) begin
            pin_oe_q <= (state_d == SRIS_ST_STAB) || (state_d == SRIS_ST_PIN) || (state_d == SRIS_ST_LV);
            int_reset_q <= (state_d == SRIS_ST_STAB) || (state_d == SRIS_ST_PIN) || (state_d == SRIS_ST_HOLD) ||
                           (state_d == SRIS_ST_LV) || (state_d == SRIS_ST_EXT);
            bus_en_q <= (state_d == SRIS_ST_RUN) || (state_d == SRIS_ST_PIN) || (state_d == SRIS_ST_HOLD) ||
                        (state_d == SRIS_ST_EXT);
        end
    end

    always_comb begin
        cause_set = '0;
        cause_set[`SRIS_CAUSE_WDOG] = ev_wdog && !lv_sync_q;
        cause_set[`SRIS_CAUSE_ILLEGAL_OPCODE_FLAG] = ev_illegal_opcode_flag && !lv_sync_q;
        cause_set[`SRIS_CAUSE_ILLEGAL_ADDRESS_FLAG] = ev_illegal_address_flag && !lv_sync_q;
        cause_set[`SRIS_CAUSE_LVI] = lv_sync_q && state_q != SRIS_ST_LV;
        cause_set[`SRIS_CAUSE_PIN] = state_d == SRIS_ST_EXT && state_q != SRIS_ST_EXT;
    end

    // Cause bits clear on read; a new cause in the same cycle still lands
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cause_q <= `SRIS_CAUSE_RESET;
        end else if (ce_in) begin
            if (rd_in && addr_in == `SRIS_ADDR_CAUSE) begin
                cause_q <= cause_set;
            end else begin
                cause_q <= cause_q | cause_set;
            end
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            config_q <= `SRIS_CONFIG_RESET;
        end else if (ce_in && wr_in && addr_in == `SRIS_ADDR_CONFIG) begin
            config_q <= wdata_in[3:0];
        end
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            rdata_q <= '0;
        end else if (ce_in) begin
            if (rd_in) begin
                case (addr_in)
                    `SRIS_ADDR_CAUSE: rdata_q <= {2'h0, cause_q};
                    `SRIS_ADDR_CONFIG: rdata_q <= {4'h0, config_q};
                    `SRIS_ADDR_STATUS: rdata_q <= {irq_valid_out, 4'h0, state_q};
                    default: rdata_q <= '0;
                endcase
            end else begin
                rdata_q <= '0;
            end
        end
    end

    sris_irq_arbiter #(
        .IRQ_COUNT(IRQ_COUNT),
        .IDX_WIDTH(IDX_WIDTH)
    ) u_arb (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .clear_in(int_reset_q),
        .take_in((cpu_in.instr_boundary || cpu_in.rti_done) && state_q == SRIS_ST_RUN),
        .mask_in(cpu_in.global_mask),
        .serviced_in(cpu_in.serviced),
        .req_in(irq_req_in),
        .enable_in(irq_enable_in),
        .valid_out(irq_valid_out),
        .index_out(irq_index_out)
    );

    assign reset_pin_out = 1'b0;
    assign reset_pin_oe_out = pin_oe_q;
    assign internal_reset_out = int_reset_q;
    assign bus_clk_enable_out = bus_en_q;
    assign rdata_out = rdata_q;

    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);

    sequence pin_phase_end_s;
        state_q == SRIS_ST_PIN && cnt_q == `SRIS_PIN_LOW_CYCLES - 6'h01 && ce_in && !lv_sync_q;
    endsequence

    wdog_reset_a: assert property ((ev_wdog && ce_in && !lv_sync_q)
        |=> state_q == SRIS_ST_PIN && cause_q[`SRIS_CAUSE_WDOG] && internal_reset_out)
        else $error("Watchdog overflow gave no reset");
    pin_driven_a: assert property ((state_q == SRIS_ST_PIN || state_q == SRIS_ST_LV)
        |-> reset_pin_oe_out && !reset_pin_out)
        else $error("Reset pin not driven low");
    pin_to_hold_a: assert property (pin_phase_end_s
        |=> state_q == SRIS_ST_HOLD && !reset_pin_oe_out && internal_reset_out)
        else $error("Pin phase length wrong");
    illegal_opcode_flag_cause_a: assert property ((ev_illegal_opcode_flag && ce_in && !lv_sync_q)
        |=> cause_q[`SRIS_CAUSE_ILLEGAL_OPCODE_FLAG] && state_q == SRIS_ST_PIN)
        else $error("Illegal opcode gave no reset");
    stop_illegal_a: assert property ((state_q == SRIS_ST_RUN && cpu_in.stop_exec && ce_in && !lv_sync_q
        && !config_q[`SRIS_CFG_STOP_ENABLE]) |=> state_q == SRIS_ST_PIN)
        else $error("Disabled stop did not reset");
    data_fetch_a: assert property ((state_q == SRIS_ST_RUN && !cpu_in.opcode_fetch && !ev_illegal_opcode_flag && !ev_wdog
        && !lv_sync_q && ext_sync_q && !cpu_in.stop_exec && ce_in) |=> state_q == SRIS_ST_RUN)
        else $error("Data fetch caused a reset");
    stop_clears_a: assert property ((state_q == SRIS_ST_RUN && state_d == SRIS_ST_STOP && ce_in)
        |=> stab_clear_q ##1 (!stab_clear_q || state_q != SRIS_ST_STOP))
        else $error("Stop did not clear the counter");
    stab_clocks_off_a: assert property ((state_q == SRIS_ST_STAB || state_q == SRIS_ST_STOPREC)
        |-> !bus_clk_enable_out)
        else $error("Clocks active during stabilisation");
    ext_no_clear_a: assert property ((state_q == SRIS_ST_EXT && ce_in) |=> !stab_clear_q)
        else $error("Pin reset cleared the counter");

endmodule

// ### core/sris_params.svh
// Constants of the reset and interrupt sequencer: offsets, bit positions, reset values, cycle counts.
// Assumes inclusion by bare name from files under core/.
`ifndef SRIS_PARAMS_SVH
`define SRIS_PARAMS_SVH

// Register port addresses (16-bit address space)
`define SRIS_ADDR_CAUSE 16'h0000
`define SRIS_ADDR_CONFIG 16'h0001
`define SRIS_ADDR_STATUS 16'h0002
`define SRIS_ADDR_WDOG_SERVICE 16'hffff

// Reset cause register bit positions
`define SRIS_CAUSE_POR 0
`define SRIS_CAUSE_PIN 1
`define SRIS_CAUSE_WDOG 2
`define SRIS_CAUSE_ILLEGAL_OPCODE_FLAG 3
`define SRIS_CAUSE_ILLEGAL_ADDRESS_FLAG 4
`define SRIS_CAUSE_LVI 5
`define SRIS_CAUSE_RESET 6'h01

// Config register bit positions and reset value
`define SRIS_CFG_STOP_ENABLE 0
`define SRIS_CFG_SHORT_STOP_REC 1
`define SRIS_CFG_BREAK_WDOG_DIS 2
`define SRIS_CFG_WDOG_ENABLE 3
`define SRIS_CONFIG_RESET 4'h8

// Counter stages and cycle counts of the 4x oscillator clock
`define SRIS_STAB_STAGES 12
`define SRIS_SERVICE_LO_STAGE 4
`define SRIS_SHORT_REC_STAGE 5
`define SRIS_PIN_LOW_CYCLES 6'h20
`define SRIS_HOLD_CYCLES 6'h20

`endif

// ### core/sris_pkg.sv
// Types shared by the reset and interrupt sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
package sris_pkg;

    typedef enum logic [2:0] {
        SRIS_ST_RUN = 3'b000,
        SRIS_ST_STAB = 3'b001,
        SRIS_ST_PIN = 3'b010,
        SRIS_ST_HOLD = 3'b011,
        SRIS_ST_LV = 3'b100,
        SRIS_ST_STOP = 3'b101,
        SRIS_ST_STOPREC = 3'b110,
        SRIS_ST_EXT = 3'b111
    } sris_state_type;

    typedef struct packed {
        logic instr_boundary;
        logic rti_done;
        logic global_mask;
        logic opcode_fetch;
        logic addr_unmapped;
        logic illegal_opcode;
        logic stop_exec;
        logic wake;
        logic break_active;
        logic monitor_mode;
        logic serviced;
    } sris_cpu_type;

endpackage

// ### core/sris_stab_counter.sv
// Stabilisation counter: twelve counting stages and a thirteenth stage, on the falling clock edge.
// Assumes clear and service requests are one-cycle flops from the rising-edge logic of the same clock.
`timescale 1ns/1ps
`include "sris_params.svh"

module sris_stab_counter
    import sris_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic clear_in,
    input wire logic service_in,
    output logic [`SRIS_STAB_STAGES-1:0] count_out,
    output logic tick_out
);

    logic [`SRIS_STAB_STAGES-1:0] count_q;
    logic stage13_q;

    // Falling edge so the rising-edge sequencer sees a settled value
    always_ff @(negedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            count_q <= '0;
        end else if (ce_in) begin
            if (clear_in) begin
                count_q <= '0;
            end else if (service_in) begin
                count_q <= {{(`SRIS_STAB_STAGES-`SRIS_SERVICE_LO_STAGE){1'b0}},
                            count_q[`SRIS_SERVICE_LO_STAGE-1:0]};
            end else begin
                count_q <= count_q + 1'b1;
            end
        end
    end

    // Carry into the thirteenth stage wraps the counter and clocks the watchdog
    always_ff @(negedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            stage13_q <= 1'b0;
        end else if (ce_in) begin
            stage13_q <= !clear_in && !service_in && (&count_q);
        end
    end

    assign count_out = count_q;
    assign tick_out = stage13_q;

    stage_wrap_a: assert property (@(negedge clk_in) disable iff (rst_in)
        (ce_in && !clear_in && !service_in && (&count_q)) |=> (count_q == '0) && stage13_q)
        else $error("Thirteenth stage did not wrap the counter");

endmodule

// ### core/sris_irq_arbiter.sv
// Interrupt latch and priority arbiter; source 0 has the highest priority.
// Assumes CPU strobes come from logic on the same clock.
`timescale 1ns/1ps

module sris_irq_arbiter
    import sris_pkg::*;
#(
    parameter int IRQ_COUNT = 8,
    parameter int IDX_WIDTH = 3
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic clear_in,
    input wire logic take_in,
    input wire logic mask_in,
    input wire logic serviced_in,
    input wire logic [IRQ_COUNT-1:0] req_in,
    input wire logic [IRQ_COUNT-1:0] enable_in,
    output logic valid_out,
    output logic [IDX_WIDTH-1:0] index_out
);

    logic valid_q;
    logic [IDX_WIDTH-1:0] index_q;
    logic mask_prev_q;
    logic [IRQ_COUNT-1:0] live;

    function automatic logic [IDX_WIDTH-1:0] pick_first(input logic [IRQ_COUNT-1:0] v);
        logic [IDX_WIDTH-1:0] r;
        r = '0;
        for (int i = IRQ_COUNT - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = IDX_WIDTH'(i);
            end
        end
        return r;
    endfunction

    assign live = req_in & enable_in;

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            mask_prev_q <= 1'b1;
        end else if (ce_in) begin
            mask_prev_q <= mask_in;
        end
    end

    // A latched request holds until serviced, the global mask falls or an internal reset clears it
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            valid_q <= 1'b0;
            index_q <= '0;
        end else if (ce_in) begin
            if (clear_in || serviced_in || (mask_prev_q && !mask_in)) begin
                valid_q <= 1'b0;
            end else if (!valid_q && take_in && !mask_in && (|live)) begin
                valid_q <= 1'b1;
                index_q <= pick_first(live);
            end
        end
    end

    assign valid_out = valid_q;
    assign index_out = index_q;

    latch_holds_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (valid_q && ce_in && !clear_in && !serviced_in && !(mask_prev_q && !mask_in))
        |=> valid_q && $stable(index_q))
        else $error("Latched interrupt was displaced");

    masked_take_a: assert property (@(posedge clk_in) disable iff (rst_in)
        (!valid_q && ce_in && take_in && mask_in) |=> !valid_q)
        else $error("Interrupt latched while masked");

endmodule

// ### verification/sris_cpu_model.sv
// CPU core model: passes the bench's strobes through and acknowledges latched interrupts.
// Assumes the same clock as the sequencer; the service delay is set by the bench.
`timescale 1ns/1ps

module sris_cpu_model
    import sris_pkg::*;
(
    input wire logic clk_in,
    input wire logic rst_in,
    input wire sris_cpu_type drive_in,
    input wire logic [3:0] delay_in,
    input wire logic irq_valid_in,
    output sris_cpu_type cpu_out
);
    logic [3:0] wait_q;
    logic svc_q;

    // Vector taken only after the latch shows; a slow delay lets the bench try to displace it
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            wait_q <= 4'h0;
            svc_q <= 1'b0;
        end else begin
            svc_q <= irq_valid_in && !svc_q && (wait_q == delay_in);
            wait_q <= (irq_valid_in && !svc_q) ? wait_q + 4'h1 : 4'h0;
        end
    end

    always_comb begin
        cpu_out = drive_in;
        cpu_out.serviced = svc_q;
    end
endmodule

// ### verification/tb_sris_top.sv
// Self-checking bench for the reset and interrupt sequencer.
// Assumes a short watchdog (WDOG_WIDTH 2) and a CPU model that services latched interrupts.
`timescale 1ns/1ps

module tb_sris_top
    import sris_pkg::*;
;
    logic clk_in = 0, rst_in = 1, wr_in = 0, rd_in = 0, rd_seen = 0;
    logic [15:0] addr_in = 16'h0000;
    logic [7:0] wdata_in = 8'h00, rdata_out, irq_req_in = 8'h00, irq_enable_in = 8'hff;
    logic [3:0] delay = 4'h3;
    logic pin, oe, internal_reset, bus_en, valid, ext_rst_n = 1, lv = 0;
    logic [2:0] idx;
    sris_cpu_type drv = '0, cpu;
    logic [7:0] exp_q[$];
    int n_errors = 0, n_checks = 0, n, seed = 32'hc38efbf7;

    always #25 clk_in = ~clk_in;

    sris_top #(.WDOG_WIDTH(2)) u_dut(.clk_in(clk_in), .rst_in(rst_in), .ce_in(1'b1), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .cpu_in(cpu),
        .irq_req_in(irq_req_in), .irq_enable_in(irq_enable_in), .ext_reset_n_in(ext_rst_n),
        .low_voltage_in(lv), .reset_pin_out(pin), .reset_pin_oe_out(oe), .internal_reset_out(internal_reset),
        .bus_clk_enable_out(bus_en), .irq_valid_out(valid), .irq_index_out(idx));

    sris_cpu_model u_cpu(.clk_in(clk_in), .rst_in(rst_in), .drive_in(drv), .delay_in(delay),
        .irq_valid_in(valid), .cpu_out(cpu));

    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task end_of_test;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task rd(input logic [15:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk_in) begin rd_in <= 1'b1; addr_in <= a; end
        @(posedge clk_in) rd_in <= 1'b0;
    endtask

    task wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_in) begin wr_in <= 1'b1; addr_in <= a; wdata_in <= d; end
        @(posedge clk_in) wr_in <= 1'b0;
    endtask

    // Read data stand one cycle only, so they are compared at the edge that follows the strobe
    always @(posedge clk_in) begin
        if (rd_seen) check("rdata", rdata_out, exp_q.pop_front());
        rd_seen <= rd_in;
    end

    task pulse(input sris_cpu_type f);
        @(posedge clk_in) drv <= drv | f;
        @(posedge clk_in) drv <= drv & ~f;
    endtask

    task seq(input logic [7:0] cause);
        n = 0;
        while (!oe && n < 8) begin @(posedge clk_in); n++; end
        n = 0;
        while (oe && n < 100) begin @(posedge clk_in); n++; end
        check("pin low cycles", n, 32);
        n = 0;
        while (internal_reset && n < 100) begin @(posedge clk_in); n++; end
        check("hold cycles", n, 32);
        rd(16'h0000, cause);
    endtask

    initial begin
        repeat (8) @(posedge clk_in);
        check("reset in reset", {internal_reset, bus_en, oe, pin}, 4'b1010);
        rst_in <= 1'b0;
        n = 0;
        while (!bus_en && n < 6000) begin @(posedge clk_in); n++; end
        check("clocks off length", n >= 4096 && n <= 4100, 1);
        while (internal_reset && n < 6000) begin @(posedge clk_in); n++; end
        check("power-on length", n >= 4160 && n <= 4170, 1);
        rd(16'h0000, 8'h01);
        rd(16'h0001, 8'h08);
        rd(16'h0003, 8'h00);
        rd(16'h0000, 8'h00);
        pulse('{illegal_opcode: 1'b1, default: 1'b0});
        seq(8'h08);
        pulse('{stop_exec: 1'b1, default: 1'b0});
        seq(8'h08);
        pulse('{opcode_fetch: 1'b1, addr_unmapped: 1'b1, default: 1'b0});
        seq(8'h10);
        pulse('{addr_unmapped: 1'b1, default: 1'b0});
        repeat (4) @(posedge clk_in);
        check("data fetch reset", {oe, internal_reset}, 2'b00);
        lv <= 1'b1;
        repeat (6) @(posedge clk_in);
        check("low voltage", {oe, internal_reset, bus_en}, 3'b110);
        lv <= 1'b0;
        n = 0;
        while (internal_reset && n < 6000) begin @(posedge clk_in); n++; end
        check("low voltage length", n >= 4160 && n <= 4170, 1);
        rd(16'h0000, 8'h20);
        irq_req_in <= 8'h0c;
        drv.global_mask <= 1'b1;
        pulse('{instr_boundary: 1'b1, default: 1'b0});
        @(posedge clk_in) drv.global_mask <= 1'b0;
        check("masked irq", valid, 0);
        irq_enable_in <= 8'hfb;
        pulse('{instr_boundary: 1'b1, default: 1'b0});
        @(posedge clk_in) irq_req_in <= 8'h0d;
        @(posedge clk_in);
        check("irq index", {valid, idx}, 4'hb);
        n = 0;
        while (valid && n < 20) begin @(posedge clk_in); n++; end
        irq_enable_in <= 8'hfe;
        pulse('{rti_done: 1'b1, default: 1'b0});
        @(posedge clk_in);
        check("irq after return", {valid, idx}, 4'ha);
        rd(16'h0002, 8'h80);
        wr(16'h0001, {4'($random(seed)), 4'hb});
        rd(16'h0001, 8'h0b);
        pulse('{stop_exec: 1'b1, default: 1'b0});
        @(posedge clk_in);
        check("stop clocks", bus_en, 0);
        pulse('{wake: 1'b1, default: 1'b0});
        n = 0;
        while (!bus_en && n < 100) begin @(posedge clk_in); n++; end
        check("short stop recovery", n >= 32 && n <= 36, 1);
        wr(16'hffff, 8'($random(seed)));
        ext_rst_n <= 1'b0;
        repeat (6) @(posedge clk_in);
        check("pin reset", {oe, internal_reset, bus_en}, 3'b011);
        ext_rst_n <= 1'b1;
        n = 6;
        while (!oe && n < 20000) begin @(posedge clk_in); n++; end
        check("watchdog span", n >= 16368 && n <= 16390, 1);
        seq(8'h06);
        end_of_test;
    end

    initial begin
        #(30000 * 50);
        n_errors++;
        end_of_test;
    end
endmodule
